/* File: src/mpp_pkg.sv */
// mpp_pkg: constants, types and crc helper shared by both link ends
// assumes a single 25 MHz clock on both ends
package mpp_pkg;
    // clock and link timing
    localparam int CLK_NS       = 40;
    localparam int FAST_BIT_NS  = 12500;   // 80 kbps
    localparam int SLOW_BIT_NS  = 31250;   // 32 kbps
    localparam int NOM_BIT_NS   = 14300;   // 70 kbps
    localparam int DRIFT_PCT    = 11;
    localparam int BIT_MIN_CYC  = FAST_BIT_NS * (100 - DRIFT_PCT) / 100 / CLK_NS;
    localparam int SYNC_LIM_CYC = SLOW_BIT_NS * (100 + DRIFT_PCT) * 3 / 200 / CLK_NS;
    localparam int RESP_DLY_NS  = 50000;
    localparam int RESP_MAX_NS  = 150000;
    localparam int RESP_DLY_CYC = RESP_DLY_NS / CLK_NS;
    localparam int RESP_TO_CYC  = RESP_MAX_NS / CLK_NS + 1;
    localparam int PGM_SETUP_NS = 40000;
    localparam int PGM_SETUP_CYC = (PGM_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_MS       = 8;
    localparam int ACC_CYC      = ACC_MS * 1000000 / CLK_NS;
    localparam int ACC_W        = 18;
    localparam int CNT_W        = 12;
    // frame layout
    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 30;
    localparam int USER_W    = 24;
    localparam int RD_BITS   = 10;         // rw, address, crc
    localparam int WR_BITS   = 40;         // rw, address, data, crc
    localparam int RESP_BITS = 35;         // sync, data, crc
    localparam int GAP_BITS  = 2;
    localparam int SPACE_BIT = 5;
    localparam logic SPACE_EE = 1'b0;
    localparam logic [2:0] CRC_INIT = 3'h7;
    localparam logic [ADDR_W-1:0] ACC_ADDR = 6'h24;
    localparam logic [DATA_W-1:0] ACC_DATA = 30'h27811f77;
    localparam int FIFO_D    = 8;
    localparam int FIFO_W    = 1 + ADDR_W + USER_W;

    typedef logic [ADDR_W-1:0] mpp_addr_t;
    typedef logic [DATA_W-1:0] mpp_word_t;
    typedef logic [USER_W-1:0] mpp_user_t;

    // crc x3+x+1 over the low n bits of d, msb first, preset 111
    function automatic logic [2:0] mpp_crc(input logic [36:0] d, input int n);
        logic [2:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = 36; i >= 0; i--)
        begin
            if (i < n)
            begin
                fb = c[2] ^ d[i];
                c  = {c[1], c[0] ^ fb, fb};
            end
        end
        return c;
    endfunction
endpackage

/* File: src/mpp_link_if.sv */
// mpp_link_if: the supply line and the two-way sensor output pin
// assumes the output pin is pulled high while nobody drives it
`timescale 1ns/1ps
`default_nettype none
interface mpp_link_if;
    logic supply_line;   // 1 = coded high level, 0 = coded low level
    logic sout_o;
    logic sout_oe;
    logic sout_line;

    // pin level resolved from the device enable, pull-up otherwise
    assign sout_line = sout_oe ? sout_o : 1'b1;

    modport dev (input supply_line, output sout_o, output sout_oe);
    modport ctl (output supply_line, input sout_line);
endinterface
`default_nettype wire

/* File: src/mpp_dev.sv */
// mpp_dev: sensor end of the manchester program port, plus its write fifo
// assumes supply_line is asynchronous and ref_clk is 25 MHz
//
// Behaviour
// - one is falling mid edge, zero rising
// - frame opens with two zero sync bits
// - direction bit zero writes, one reads
// - six bit address follows direction bit
// - address bit five low selects eeprom
// - write data field thirty bits, 24 used
// - three bit crc closes every frame
// - read command has no data field
// - controller sends access code within 8 ms
// - decode any rate from 32 to 80 kbps
// - 70 kbps bit lasts 13.6 to 15 us
// - tolerate eleven percent drift inside a frame
// - two bit gap after register write
// - two bit gap after second program pulse
// - two bit gap after read response
// - response starts 50 us minus quarter bit
// - 40 us before an eeprom program pulse
// - supply held normal until first sync
// - supply back to normal within 15 us
// - crc preset 111, bad crc frame ignored
// - address and data sent msb first
// - no access code by deadline locks port
// - response is sync, thirty data bits, crc
`timescale 1ns/1ps
`default_nettype none
module mpp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [D-1:0]        vld;
    } mpp_fifo_state_t;

    mpp_fifo_state_t s;
    mpp_fifo_state_t next_s;

    // shift register queue: entry 0 is the head, so outputs are flops
    always_comb
    begin
        logic done;
        next_s = s;
        done   = 1'b0;
        if (s.vld[0] && out_ready)
        begin
            next_s.mem = s.mem >> W;
            next_s.vld = s.vld >> 1;
        end
        if (in_valid && !s.vld[D-1])
        begin
            for (int i = 0; i < D; i++)
            begin
                if (!done && !next_s.vld[i])
                begin
                    next_s.mem[i] = in_data;
                    next_s.vld[i] = 1'b1;
                    done          = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign in_ready  = !s.vld[D-1];   // full only when the last slot holds data
    assign out_valid = s.vld[0];
    assign out_data  = s.mem[0];
endmodule

module mpp_dev
    import mpp_pkg::*;
#(
    parameter int ACC_LIM = ACC_CYC
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // link
    mpp_link_if.dev            link,
    // read requests and their data
    output logic               rd_req,
    output mpp_pkg::mpp_addr_t rd_addr,
    output logic               rd_eeprom,
    input  wire mpp_pkg::mpp_word_t rd_data,
    // accepted writes
    output logic               wr_valid,
    input  wire logic          wr_ready,
    output mpp_pkg::mpp_addr_t wr_addr,
    output mpp_pkg::mpp_user_t wr_data,
    output logic               wr_eeprom,
    output logic               wr_lost,
    // access state
    output logic               access_granted,
    output logic               access_locked
);
    import mpp_pkg::*;

    typedef enum logic [4:0] {
        D_IDLE = 5'h01,
        D_SYNC = 5'h02,
        D_BITS = 5'h04,
        D_WAIT = 5'h08,
        D_SEND = 5'h10
    } mpp_dst_t;

    typedef struct packed {
        mpp_dst_t             st;
        logic                 s1;
        logic                 s2;
        logic                 s3;
        logic [CNT_W-1:0]     cnt;
        logic [CNT_W-1:0]     bit_period;
        logic [1:0]           nedge;
        logic [5:0]           nbit;
        logic [WR_BITS-1:0]   sh;
        logic [RESP_BITS-1:0] resp;
        logic                 ph;
        logic [ACC_W-1:0]     acc_cnt;
        logic                 granted;
        logic                 locked;
        logic                 rd_req;
        mpp_addr_t            rd_addr;
        logic                 rd_eeprom;
        logic                 push;
        logic [FIFO_W-1:0]    pdata;
        logic                 wr_lost;
        logic                 out_o;
        logic                 out_oe;
    } mpp_dev_state_t;

    mpp_dev_state_t    s;
    mpp_dev_state_t    next_s;
    logic              edge_seen;
    logic              rd_ok;
    logic              wr_ok;
    logic              fifo_rdy;
    logic [FIFO_W-1:0] fifo_q;
    mpp_addr_t         ra;
    mpp_addr_t         wa;
    mpp_word_t         wd;

    // field decode of the shift register, msb first
    assign edge_seen = s.s2 ^ s.s3;
    assign ra = s.sh[8:3];
    assign wa = s.sh[38:33];
    assign wd = s.sh[32:3];
    assign rd_ok = (s.nbit == 6'(RD_BITS)) && s.sh[RD_BITS-1]
        && (mpp_crc({30'h0, s.sh[9:3]}, 7) == s.sh[2:0]);
    assign wr_ok = (s.nbit == 6'(WR_BITS)) && !s.sh[WR_BITS-1]
        && (mpp_crc(s.sh[39:3], 37) == s.sh[2:0]);

    // receive, validate, answer and police the access deadline
    always_comb
    begin
        next_s         = s;
        next_s.s1      = link.supply_line;
        next_s.s2      = s.s1;
        next_s.s3      = s.s2;
        next_s.rd_req  = 1'b0;
        next_s.push    = 1'b0;
        next_s.wr_lost = 1'b0;
        if (!s.granted && !s.locked)
        begin
            if (s.acc_cnt == ACC_LIM[ACC_W-1:0])
                next_s.locked = 1'b1;
            else
                next_s.acc_cnt = s.acc_cnt + 1'b1;
        end
        unique case (s.st)
            D_IDLE:
            begin
                if (edge_seen && s.s3)
                begin
                    next_s.st    = D_SYNC;
                    next_s.cnt   = '0;
                    next_s.nedge = '0;
                end
            end
            D_SYNC:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == CNT_W'(SYNC_LIM_CYC))
                    next_s.st = D_IDLE;
                else if (edge_seen)
                begin
                    // zero sync bits: rising, falling, rising
                    if (s.s2 != (s.nedge != 2'h1))
                        next_s.st = D_IDLE;
                    else if (s.nedge == 2'h0)
                        next_s.nedge = 2'h1;
                    else if (s.nedge == 2'h1)
                    begin
                        // the count starts one cycle after the first fall, so add it back
                        next_s.bit_period  = s.cnt + 1'b1;
                        next_s.nedge = 2'h2;
                        if (s.cnt < CNT_W'(BIT_MIN_CYC))
                            next_s.st = D_IDLE;
                    end
                    else
                    begin
                        next_s.st   = D_BITS;
                        next_s.cnt  = '0;
                        next_s.nbit = '0;
                    end
                end
            end
            D_BITS:
            begin
                next_s.cnt = s.cnt + 1'b1;
                // boundary edges fall before three quarters of a bit
                if (edge_seen && s.cnt >= s.bit_period - (s.bit_period >> 2))
                begin
                    next_s.sh  = {s.sh[WR_BITS-2:0], s.s3};
                    next_s.cnt = '0;
                    if (s.nbit != 6'h3f)
                        next_s.nbit = s.nbit + 1'b1;
                end
                else if (s.cnt >= s.bit_period + (s.bit_period >> 1))
                begin
                    next_s.st = D_IDLE;
                    if (wr_ok)
                    begin
                        if (wa == ACC_ADDR && wd == ACC_DATA && !s.locked)
                            next_s.granted = 1'b1;
                        else if (s.granted)
                        begin
                            next_s.push    = fifo_rdy;
                            next_s.wr_lost = !fifo_rdy;
                            next_s.pdata   = {wa[SPACE_BIT] == SPACE_EE, wa,
                                              wd[USER_W-1:0]};
                        end
                    end
                    else if (rd_ok && s.granted)
                    begin
                        next_s.rd_req    = 1'b1;
                        next_s.rd_addr   = ra;
                        next_s.rd_eeprom = ra[SPACE_BIT] == SPACE_EE;
                        next_s.st        = D_WAIT;
                        next_s.cnt       = '0;
                    end
                end
            end
            D_WAIT:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == CNT_W'(RESP_DLY_CYC) - (s.bit_period >> 2))
                begin
                    next_s.resp = {2'b00, rd_data,
                                   mpp_crc({7'h0, rd_data}, DATA_W)};
                    next_s.st   = D_SEND;
                    next_s.cnt  = '0;
                    next_s.nbit = '0;
                    next_s.ph   = 1'b0;
                end
            end
            D_SEND:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == (s.bit_period >> 1) - 1'b1)
                begin
                    next_s.cnt = '0;
                    next_s.ph  = !s.ph;
                    if (s.ph)
                    begin
                        next_s.resp = s.resp << 1;
                        next_s.nbit = s.nbit + 1'b1;
                        if (s.nbit == 6'(RESP_BITS - 1))
                            next_s.st = D_IDLE;
                    end
                end
            end
        endcase
        // first half carries the bit, second half its inverse
        next_s.out_oe = next_s.st == D_SEND;
        next_s.out_o  = next_s.ph ^ next_s.resp[RESP_BITS-1];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s       <= '0;
            s.st    <= D_IDLE;
            s.s1    <= 1'b1;
            s.s2    <= 1'b1;
            s.s3    <= 1'b1;
            s.out_o <= 1'b1;
        end
        else
            s <= next_s;
    end

    // accepted writes queue up for the memory side
    mpp_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_wr_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (s.push),
        .in_ready  (fifo_rdy),
        .in_data   (s.pdata),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_q)
    );

    // outputs
    assign wr_eeprom      = fifo_q[FIFO_W-1];
    assign wr_addr        = fifo_q[USER_W +: ADDR_W];
    assign wr_data        = fifo_q[USER_W-1:0];
    assign wr_lost        = s.wr_lost;
    assign rd_req         = s.rd_req;
    assign rd_addr        = s.rd_addr;
    assign rd_eeprom      = s.rd_eeprom;
    assign access_granted = s.granted;
    assign access_locked  = s.locked;
    assign link.sout_o    = s.out_o;
    assign link.sout_oe   = s.out_oe;
endmodule
`default_nettype wire

/* File: src/mpp_ctl.sv */
// mpp_ctl: programming controller end of the manchester program port
// assumes sout_line is asynchronous and ref_clk is 25 MHz
`timescale 1ns/1ps
`default_nettype none
module mpp_ctl
    import mpp_pkg::*;
#(
    parameter int HALF_CYC = NOM_BIT_NS / CLK_NS / 2
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // link
    mpp_link_if.ctl            link,
    // commands
    input  wire logic          cmd_valid,
    output logic               cmd_ready,
    input  wire logic          cmd_read,
    input  wire mpp_pkg::mpp_addr_t cmd_addr,
    input  wire mpp_pkg::mpp_word_t cmd_data,
    // read answers
    output logic               resp_valid,
    output mpp_pkg::mpp_word_t resp_data,
    output logic               resp_ok
);
    import mpp_pkg::*;

    localparam int CW = 16;
    localparam int FW = 2 + WR_BITS;

    typedef enum logic [4:0] {
        C_IDLE = 5'h01,
        C_TX   = 5'h02,
        C_WAIT = 5'h04,
        C_RX   = 5'h08,
        C_GAP  = 5'h10
    } mpp_cst_t;

    typedef struct packed {
        mpp_cst_t      st;
        logic          s1;
        logic          s2;
        logic          s3;
        logic [CW-1:0] cnt;
        logic [5:0]    nb;
        logic [FW-1:0] sh;
        logic          ph;
        logic          rd;
        logic          ee;
        logic          rdy;
        logic          rv;
        mpp_word_t     rdat;
        logic          rok;
        logic          sup;
    } mpp_ctl_state_t;

    mpp_ctl_state_t s;
    mpp_ctl_state_t next_s;
    logic [CW-1:0]  gap_lim;

    // eeprom writes leave room for the programming pulse
    assign gap_lim = s.ee ? CW'(PGM_SETUP_CYC)
                          : CW'(2 * (GAP_BITS + 1) * HALF_CYC);

    // send frames, collect answers, keep the gaps
    always_comb
    begin
        next_s    = s;
        next_s.s1 = link.sout_line;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.rv = 1'b0;
        unique case (s.st)
            C_IDLE:
            begin
                if (cmd_valid)
                begin
                    next_s.rdy = 1'b0;
                    next_s.rd  = cmd_read;
                    next_s.ee  = !cmd_read && cmd_addr[SPACE_BIT] == SPACE_EE;
                    next_s.st  = C_TX;
                    next_s.cnt = '0;
                    next_s.ph  = 1'b0;
                    if (cmd_read)
                    begin
                        next_s.sh = {3'b001, cmd_addr,
                                     mpp_crc({30'h0, 1'b1, cmd_addr}, 7),
                                     30'h0};
                        next_s.nb = 6'(2 + RD_BITS);
                    end
                    else
                    begin
                        next_s.sh = {3'b000, cmd_addr, cmd_data,
                                     mpp_crc({1'b0, cmd_addr, cmd_data}, 37)};
                        next_s.nb = 6'(FW);
                    end
                end
            end
            C_TX:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == CW'(HALF_CYC - 1))
                begin
                    next_s.cnt = '0;
                    next_s.ph  = !s.ph;
                    if (s.ph)
                    begin
                        next_s.sh = s.sh << 1;
                        next_s.nb = s.nb - 1'b1;
                        if (s.nb == 6'h1)
                            next_s.st = s.rd ? C_WAIT : C_GAP;
                    end
                end
            end
            C_WAIT:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.s3 && !s.s2)
                begin
                    next_s.st  = C_RX;
                    next_s.cnt = '0;
                    next_s.nb  = '0;
                end
                else if (s.cnt == CW'(RESP_TO_CYC))
                begin
                    next_s.rv  = 1'b1;
                    next_s.rok = 1'b0;
                    next_s.st  = C_GAP;
                    next_s.cnt = '0;
                end
            end
            C_RX:
            begin
                next_s.cnt = s.cnt + 1'b1;
                // sample each first half, a quarter bit in
                if ((s.nb == 6'h0 && s.cnt == CW'(HALF_CYC / 2))
                    || s.cnt == CW'(2 * HALF_CYC - 1))
                begin
                    next_s.cnt = '0;
                    next_s.sh  = {s.sh[FW-2:0], s.s2};
                    next_s.nb  = s.nb + 1'b1;
                    if (s.nb == 6'(RESP_BITS - 1))
                    begin
                        next_s.rv   = 1'b1;
                        next_s.rdat = next_s.sh[32:3];
                        next_s.rok  = next_s.sh[34:33] == 2'b00
                            && mpp_crc({7'h0, next_s.sh[32:3]}, DATA_W)
                               == next_s.sh[2:0];
                        next_s.st   = C_GAP;
                    end
                end
            end
            C_GAP:
            begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == gap_lim)
                begin
                    next_s.st  = C_IDLE;
                    next_s.rdy = 1'b1;
                end
            end
        endcase
        // supply sits at the normal level outside transmission
        next_s.sup = (next_s.st == C_TX) ? (next_s.ph ^ next_s.sh[FW-1])
                                         : 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s     <= '0;
            s.st  <= C_IDLE;
            s.s1  <= 1'b1;
            s.s2  <= 1'b1;
            s.s3  <= 1'b1;
            s.rdy <= 1'b1;
            s.sup <= 1'b1;
        end
        else
            s <= next_s;
    end

    // outputs
    assign cmd_ready        = s.rdy;
    assign resp_valid       = s.rv;
    assign resp_data        = s.rdat;
    assign resp_ok          = s.rok;
    assign link.supply_line = s.sup;
endmodule
`default_nettype wire

/* File: dv/mpp_checker.sv */
// mpp_checker: assertions on the link between the controller and device ends
// assumes one clock domain; H is the controller half bit in cycles
`timescale 1ns/1ps
`default_nettype none
module mpp_checker #(
    parameter int H = 156
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link
    input wire logic supply_line,
    input wire logic sout_o,
    input wire logic sout_oe,
    input wire logic sout_line
);
    localparam int RD_MIN = 625 - H / 2;
    localparam int RD_MAX = 3750 + H / 2;
    logic [15:0] q;   // cycles since the supply last changed
    logic [15:0] lo;  // length of the current low run on the supply
    logic [15:0] oc;  // cycles the device pin has been driven
    logic [15:0] gp;  // cycles since the device released the pin
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // helper counters, q and gp saturating, lo and oc wrapping
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q  <= 16'hffff;
            lo <= 16'h0;
            oc <= 16'h0;
            gp <= 16'hffff;
        end
        else
        begin
            q  <= $changed(supply_line) ? 16'h0 : q + {15'h0, q != 16'hffff};
            lo <= supply_line ? 16'h0 : lo + 16'h1;
            oc <= sout_oe ? oc + 16'h1 : 16'h0;
            gp <= sout_oe ? 16'h0 : gp + {15'h0, gp != 16'hffff};
        end
    end
    sequence s_reply_start;
        $rose(sout_oe);
    endsequence
    property p_resp_delay;
        s_reply_start |-> q inside {[RD_MIN:RD_MAX]};
    endproperty
    a_resp_delay: assert property (p_resp_delay) else $error("reply start late or early");
    property p_resp_len;
        $fell(sout_oe) |-> oc inside {[70 * H - 8:70 * H + 8]};
    endproperty
    a_resp_len: assert property (p_resp_len) else $error("reply length wrong");
    property p_sync_low;
        sout_oe && (oc == H / 2 || oc == 5 * H / 2) |-> !sout_o;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("reply sync first half high");
    property p_sync_high;
        sout_oe && (oc == 3 * H / 2 || oc == 7 * H / 2) |-> sout_line;
    endproperty
    a_sync_high: assert property (p_sync_high) else $error("reply sync second half low");
    property p_bit_low;
        $rose(supply_line) |-> lo <= 2 * H + 2;
    endproperty
    a_bit_low: assert property (p_bit_low) else $error("supply low beyond one bit");
    property p_supply_back;
        $rose(supply_line) |-> lo <= 375;
    endproperty
    a_supply_back: assert property (p_supply_back) else $error("supply not back in time");
    property p_resp_gap;
        $fell(supply_line) |-> gp >= 4 * H;
    endproperty
    a_resp_gap: assert property (p_resp_gap) else $error("command too soon after reply");
    property p_quiet;
        sout_oe |-> supply_line && q > 2 * H;
    endproperty
    a_quiet: assert property (p_quiet) else $error("device drives during command");
endmodule
`default_nettype wire

/* File: dv/mpp_tb_top.sv */
// mpp_tb_top: both link ends joined by the interface, driven on command and write sides
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none
module mpp_tb_top;
    import mpp_pkg::*;
    localparam int HALF = 156;
    localparam int ACC  = 15000;
    localparam mpp_word_t RDV = 30'h05c3c3c3;
    typedef struct {logic rd; mpp_addr_t addr; mpp_word_t data; logic ee;} mpp_row_t;
    logic ref_clk, rst_n, rd_req, rd_eeprom, wr_valid, wr_ready, wr_eeprom, rok, wr_lost;
    logic access_granted, access_locked, cmd_valid, cmd_ready, cmd_read, resp_valid, resp_ok;
    mpp_addr_t rd_addr, wr_addr, cmd_addr;
    mpp_word_t rd_data, cmd_data, resp_data, rsp;
    mpp_user_t wr_data;
    int        mismatches, samples_checked, cyc, nrd, nlost;
    mpp_row_t  wq [$];
    mpp_row_t  rows [4] = '{'{1'b0, ACC_ADDR, ACC_DATA, 1'b0}, '{1'b0, 6'h31, 30'h3f00a5c3, 1'b0},
                            '{1'b0, 6'h02, 30'h00123456, 1'b1}, '{1'b1, 6'h02, 30'h0, 1'b1}};
    mpp_link_if mpp_link_if_i ();
    mpp_dev #(.ACC_LIM(ACC)) mpp_dev_i (.ref_clk, .rst_n, .link(mpp_link_if_i), .rd_req, .rd_addr,
        .rd_eeprom, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_eeprom, .wr_lost,
        .access_granted, .access_locked);
    mpp_ctl #(.HALF_CYC(HALF)) mpp_ctl_i (.ref_clk, .rst_n, .link(mpp_link_if_i), .cmd_valid,
        .cmd_ready, .cmd_read, .cmd_addr, .cmd_data, .resp_valid, .resp_data, .resp_ok);
    mpp_checker #(.H(HALF)) mpp_checker_i (.ref_clk, .rst_n,
        .supply_line(mpp_link_if_i.supply_line), .sout_o(mpp_link_if_i.sout_o),
        .sout_oe(mpp_link_if_i.sout_oe), .sout_line(mpp_link_if_i.sout_line));
    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // read pulses, replies and the hang limit
    always @(posedge ref_clk)
    begin
        cyc++;
        if (rd_req === 1'b1)
            nrd++;
        if (wr_lost !== 1'b0)
            nlost++;
        if (resp_valid === 1'b1)
        begin
            rsp = resp_data;
            rok = resp_ok;
        end
        if (cyc == 100000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one command, returns when the controller is ready again
    task automatic send(input logic rd, input mpp_addr_t a, input mpp_word_t d);
        {cmd_valid, cmd_read, cmd_addr, cmd_data} = {1'b1, rd, a, d};
        @(posedge ref_clk);
        #1 cmd_valid = 1'b0;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        #1;
    endtask
    task automatic results;
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {rst_n, cmd_valid, cmd_read, cmd_addr, cmd_data, wr_ready} = '0;
        rd_data = RDV;
        repeat (8) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        chk("supply idle", 1, mpp_link_if_i.supply_line);
        chk("not granted", 0, access_granted);
        foreach (rows[i])
        begin
            send(rows[i].rd, rows[i].addr, rows[i].data);
            if (rows[i].rd)
            begin
                chk("read pulses", 1, nrd);
                chk("read addr", rows[i].addr, rd_addr);
                chk("read space", rows[i].ee, rd_eeprom);
                chk("reply data", RDV, rsp);
                chk("reply crc", 1, rok);
            end
            else if (rows[i].addr != ACC_ADDR)
                wq.push_back(rows[i]);
        end
        chk("granted", 1, access_granted);
        foreach (wq[i])
        begin
            chk("write valid", 1, wr_valid);
            chk("write addr", wq[i].addr, wr_addr);
            chk("write data", wq[i].data[23:0], wr_data);
            chk("write space", wq[i].ee, wr_eeprom);
            wr_ready = 1'b1;
            @(posedge ref_clk);
            #1 wr_ready = 1'b0;
            @(posedge ref_clk);
            #1;
        end
        chk("queue empty", 0, wr_valid);
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        chk("grant cleared", 0, access_granted);
        repeat (ACC) @(posedge ref_clk);
        #1;
        chk("not yet locked", 0, access_locked);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("locked", 1, access_locked);
        send(1'b1, 6'h02, 30'h0);
        chk("locked read", 1, nrd);
        chk("locked reply", 0, rok);
        chk("no write lost", 0, nlost);
        results();
    end
endmodule
`default_nettype wire
